// ==== bench/cmd_irq_ctrl_sva.sv ====
// Assertions on the command register interrupt controls
`timescale 1ns/1ps
module cmd_irq_ctrl_sva (
	input wire logic mclk, rst, cmd_wr, async_evict_done, microframe_tick, other_irq_pending,
	input wire logic async_advance_irq_en, async_advance_flag, doorbell_req, light_reset_active,
	input wire logic irq,
	input wire logic [31:0] cmd_wdata, cmd_rdata
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	a_flag_sets: assert property (doorbell_req && async_evict_done && !light_reset_active
		|=> async_advance_flag) else $error("flag");
	a_bell_holds: assert property (doorbell_req && !async_advance_flag && !light_reset_active
		&& !cmd_wr |=> doorbell_req) else $error("bell");
	a_bell_clears: assert property ($fell(doorbell_req)
		|-> $past(async_advance_flag) || light_reset_active) else $error("early");
	a_lrst_read: assert property (cmd_rdata[7] == light_reset_active) else $error("lr");
	a_lrst_len: assert property ($rose(light_reset_active)
		|-> ##15 light_reset_active ##1 !light_reset_active) else $error("len");
	a_lrst_clear: assert property ($fell(light_reset_active)
		|-> cmd_rdata[23:16] == 8'h08 && !doorbell_req) else $error("init");
	a_itc_write: assert property (cmd_wr && !cmd_wdata[7] && !light_reset_active
		|=> cmd_rdata[23:16] == $past(cmd_wdata[23:16])) else $error("itc");
	a_irq_cause: assert property (irq |-> $past(microframe_tick) && ($past(other_irq_pending)
		|| $past(async_advance_flag) && $past(async_advance_irq_en))) else $error("irq");
endmodule : cmd_irq_ctrl_sva

// ==== bench/cmd_irq_ctrl_tb.sv ====
// Self-checking bench for the command register interrupt controls
`timescale 1ns/1ps
module cmd_irq_ctrl_tb;
	logic mclk = 0, rst = 1, cmd_wr = 0, evict = 0, en = 0, tick = 0, flag, bell, lrst, irq;
	logic clr = 0, other = 0;
	logic [31:0] wdata = 0, rdata;
	logic [7:0] codes[7] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40};
	int n_fail = 0, compares = 0, seed = 92430, n;
	always #10 mclk = ~mclk;
	cmd_irq_ctrl dut (.mclk(mclk), .rst(rst), .cmd_wr(cmd_wr), .cmd_wdata(wdata),
		.cmd_rdata(rdata), .controller_halted_flag(1'b1), .async_sched_active(1'b1),
		.async_evict_done(evict), .async_advance_irq_en(en), .async_advance_flag_clr(clr),
		.other_irq_pending(other), .microframe_tick(tick), .async_advance_flag(flag),
		.doorbell_req(bell), .light_reset_active(lrst), .irq(irq));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic close_out;
		if (n_fail == 0 && compares > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : close_out
	task automatic wr(input logic [31:0] d);
		wdata = d;
		cmd_wr = 1;
		@(negedge mclk) cmd_wr = 0;
	endtask : wr
	// At least one idle edge between ticks so tick is set once per step
	task automatic run_ticks(output int cnt);
		cnt = 0;
		repeat (64) begin
			tick = 1;
			@(negedge mclk) tick = 0;
			cnt += irq;
			repeat (1 + $unsigned($random(seed)) % 3) @(negedge mclk) cnt += irq;
		end
	endtask : run_ticks
	initial begin
		repeat (12) @(negedge mclk);
		rst = 0;
		chk(rdata, 32'h0008_0000);
		wr(32'h0008_0040);
		repeat (3) @(negedge mclk);
		chk(rdata, 32'h0008_0040);
		evict = 1;
		en = 1;
		@(negedge mclk) evict = 0;
		chk({bell, flag}, 2'b11);
		@(negedge mclk);
		chk({bell, flag}, 2'b01);
		foreach (codes[i]) begin
			wr({8'h00, codes[i], 16'h0000});
			chk(rdata, {8'h00, codes[i], 16'h0000});
			run_ticks(n);
			chk(n, 64 / codes[i]);
		end
		clr = 1;
		@(negedge mclk) clr = 0;
		chk(flag, 1'b0);
		run_ticks(n);
		chk(n, 0);
		other = 1;
		run_ticks(n);
		other = 0;
		chk(n, 1);
		wr(32'h0040_0080);
		chk(rdata[7], 1'b1);
		wr(32'h0010_0000);
		repeat (16) @(negedge mclk);
		chk(rdata, 32'h0008_0000);
		close_out();
	end
endmodule : cmd_irq_ctrl_tb
bind cmd_irq_ctrl cmd_irq_ctrl_sva u_sva (.*);

// ==== core/cmd_irq_ctrl.sv ====
// Threshold, light reset and async-advance doorbell part of the command register
`timescale 1ns/1ps
module cmd_irq_ctrl #(
	parameter bit LRST_IMPL = 1'b1
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic cmd_wr,
	input wire logic [31:0] cmd_wdata,
	output logic [31:0] cmd_rdata,
	input wire logic controller_halted_flag,
	input wire logic async_sched_active,
	input wire logic async_evict_done,
	input wire logic async_advance_irq_en,
	input wire logic async_advance_flag_clr,
	input wire logic other_irq_pending,
	input wire logic microframe_tick,
	output logic async_advance_flag,
	output logic doorbell_req,
	output logic light_reset_active,
	output logic irq
);
	typedef enum logic [1:0] {DB_IDLE, DB_WAIT, DB_CLEAR} db_e;
	typedef struct packed {
		logic [7:0] thresh;
		logic doorbell;
		logic flag;
		db_e db_state;
		logic lrst;
		logic [7:0] lrst_cnt;
		logic [7:0] uf_cnt;
		logic irq;
	} state_s;
	state_s s_reg;
	state_s s_next;
	logic wr_door;
	logic wr_lrst;
	logic boundary;

	// ==================================================
	// Register read
	always_comb begin
		cmd_rdata = 32'h0000_0000;
		cmd_rdata[cmd_irq_pkg::THR_MSB:cmd_irq_pkg::THR_LSB] = s_reg.thresh;
		cmd_rdata[cmd_irq_pkg::DOORBELL_BIT] = s_reg.doorbell;
		cmd_rdata[cmd_irq_pkg::LRST_BIT] = LRST_IMPL & s_reg.lrst;
	end

	assign wr_door = cmd_wr & cmd_wdata[cmd_irq_pkg::DOORBELL_BIT];
	assign wr_lrst = cmd_wr & cmd_wdata[cmd_irq_pkg::LRST_BIT] & LRST_IMPL;
	// Threshold codes 1..64 compared directly against the counter plus one
	assign boundary = microframe_tick & ((s_reg.uf_cnt + 8'h01) >= s_reg.thresh);

	// ==================================================
	// Next state
	always_comb begin
		s_next = s_reg;
		s_next.irq = 1'b0;
		if (s_reg.lrst) begin
			// Light reset clears only this block; ports live elsewhere
			s_next.lrst_cnt = s_reg.lrst_cnt + 8'h01;
			s_next.thresh = cmd_irq_pkg::THR_RESET;
			s_next.doorbell = 1'b0;
			s_next.flag = 1'b0;
			s_next.db_state = DB_IDLE;
			s_next.uf_cnt = 8'h00;
			if (s_reg.lrst_cnt == cmd_irq_pkg::LRST_CYCLES - 8'h01) begin
				s_next.lrst = 1'b0;
			end
		end else begin
			if (wr_lrst) begin
				s_next.lrst = 1'b1;
				s_next.lrst_cnt = 8'h00;
			end
			// Written value taken as is; software keeps it legal while halted
			if (cmd_wr) begin
				s_next.thresh = cmd_wdata[cmd_irq_pkg::THR_MSB:cmd_irq_pkg::THR_LSB];
			end
			if (async_advance_flag_clr) begin
				s_next.flag = 1'b0;
			end
			case (s_reg.db_state)
				DB_IDLE: begin
					if (wr_door) begin
						s_next.doorbell = 1'b1;
						s_next.db_state = DB_WAIT;
					end
				end
				DB_WAIT: begin
					if (async_evict_done) begin
						s_next.flag = 1'b1;
						s_next.db_state = DB_CLEAR;
					end
				end
				DB_CLEAR: begin
					// Flag already set in the previous cycle
					s_next.doorbell = 1'b0;
					s_next.db_state = DB_IDLE;
				end
				default: begin
					s_next.db_state = DB_IDLE;
				end
			endcase
			if (microframe_tick) begin
				if (boundary) begin
					s_next.uf_cnt = 8'h00;
					s_next.irq = (s_reg.flag & async_advance_irq_en) | other_irq_pending;
				end else if (s_reg.uf_cnt != cmd_irq_pkg::THR_MAX) begin
					s_next.uf_cnt = s_reg.uf_cnt + 8'h01;
				end
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			s_reg.thresh <= cmd_irq_pkg::THR_RESET;
			s_reg.doorbell <= 1'b0;
			s_reg.flag <= 1'b0;
			s_reg.db_state <= DB_IDLE;
			s_reg.lrst <= 1'b0;
			s_reg.lrst_cnt <= 8'h00;
			s_reg.uf_cnt <= 8'h00;
			s_reg.irq <= 1'b0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign async_advance_flag = s_reg.flag;
	assign doorbell_req = s_reg.doorbell;
	assign light_reset_active = s_reg.lrst;
	assign irq = s_reg.irq;
endmodule : cmd_irq_ctrl

// ==== core/cmd_irq_pkg.sv ====
// Constants for the command register interrupt controls
// Functional notes
// - Threshold codes 08h,10h,20h,40h give 8,16,32,64 microframes between interrupts.
// - Threshold field is 8 bits, resets to 08h; 01h,02h,04h give 1,2,4.
// - If light reset is absent, its bit always reads zero.
// - Light reset reinitialises controller logic but keeps port state and companion routing.
// - Light reset bit reads one while reset runs, zero once finished.
// - After doorbell and cache eviction, controller sets the async-advance flag.
// - Flag set and enabled gives an interrupt at the next threshold boundary.
// - Doorbell clears to zero only after the async-advance flag is set.
package cmd_irq_pkg;
	localparam logic [7:0] CMD_OFFSET = 8'h20;
	localparam int THR_LSB = 16;
	localparam int THR_MSB = 23;
	localparam int LRST_BIT = 7;
	localparam int DOORBELL_BIT = 6;
	localparam logic [7:0] THR_RESET = 8'h08;
	localparam logic [7:0] THR_MAX = 8'h40;
	localparam logic [7:0] LRST_CYCLES = 8'h10;
endpackage : cmd_irq_pkg
